// [design/imm_alu.sv]
// Byte-immediate arithmetic: add, subtract, load positive, load negative
module imm_alu
#(
    parameter int DATA_W = 16,
    parameter int IMM_W  = 8
)
(
    // Operands
    input  wire logic [DATA_W-1:0]      operand,
    input  wire logic [IMM_W-1:0]       imm,
    input  wire imm_jump_pkg::alu_op_t  op,
    // Result
    output logic [DATA_W-1:0]           result
);

    import imm_jump_pkg::*;

    // Immediate is always taken as a positive byte
    logic [DATA_W-1:0] imm_ext;

    // Zero extension needs at least one spare bit above the immediate
    if (IMM_W >= DATA_W)
    begin : g_width_check
        $error("imm_alu: immediate must be narrower than the data word");
    end

    assign imm_ext = {{(DATA_W-IMM_W){1'b0}}, imm};

    // Wraps modulo the word, as the accumulator does
    always_comb
    begin
        case (op)
            ALU_ADD: result = operand + imm_ext;
            ALU_SUB: result = operand - imm_ext;
            ALU_POS: result = imm_ext;
            ALU_NEG: result = DATA_W'(0) - imm_ext;
            default: result = imm_ext;
        endcase
    end

endmodule

// [design/imm_jump_consts.svh]
// Opcode skeletons, field positions and step counts for the immediate/jump decoder
`ifndef IMM_JUMP_CONSTS_SVH
`define IMM_JUMP_CONSTS_SVH

// Byte-immediate opcodes, matched on the high byte
`define OPC_ADD_IMM_ACC        8'h0b
`define OPC_ADD_IMM_INDEX      8'hc2
`define OPC_SUB_IMM_ACC        8'h0d
`define OPC_SUB_IMM_INDEX      8'hc3
`define OPC_CMP_IMM_ACC_SKIP   8'hc0
`define OPC_CMP_IMM_INDEX_SKIP 8'hc1
`define OPC_LOAD_POS_IMM_ACC   8'hc6
`define OPC_LOAD_POS_IMM_INDEX 8'hc4
`define OPC_LOAD_NEG_IMM_ACC   8'hc7
`define OPC_LOAD_NEG_IMM_INDEX 8'hc5

// Conditional jump skeletons, matched on the whole word
`define WORD_JUMP_ACC_GT_ZERO  16'h3180
`define WORD_JUMP_SENSE_ON     16'h3400
`define WORD_JUMP_SENSE_OFF    16'h2400

// General condition jump: top nibble, then condition select bits
`define NIB_JUMP_ON_COND       4'h2
`define COND_BIT_ACC_GT_ZERO   7
`define COND_BIT_ACC_ZERO      8
`define COND_BIT_SENSE_ON      9
`define COND_BIT_ACC_MINUS     10
`define COND_BIT_INVERT        11

// Field layout of the instruction word
`define OPC_HI                 15
`define OPC_LO                 8
`define IMM_HI                 7
`define IMM_LO                 0
`define NIB_HI                 15
`define NIB_LO                 12
`define ACC_SIGN_BIT           15

// Program counter steps in words
`define PC_STEP_NEXT           16'h0001
`define PC_STEP_SKIP           16'h0002

`endif

// [design/imm_jump_decoder.sv]
// Decoder and executor for byte-immediate and conditional jump instructions
`include "imm_jump_consts.svh"

module imm_jump_decoder
#(
    parameter int DATA_W = 16
)
(
    // Clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     arst_n,
    // Fetched instruction and datapath view
    input  wire imm_jump_pkg::fetch_t     fetch,
    // Registered outcome
    output imm_jump_pkg::exec_result_t    result_q
);

    import imm_jump_pkg::*;

    // Released reset copy
    logic              rst_meta_n_q;
    logic              rst_n_q;
    // State and its next value
    dec_state_t        s_q;
    dec_state_t        s_d;
    // Decoded fields
    logic [7:0]        opcode;
    logic [7:0]        imm;
    logic              to_index;
    logic              is_imm;
    alu_op_t           alu_op;
    logic [15:0]       alu_operand;
    logic [15:0]       alu_result;
    logic              acc_gt_zero;

    // Structs hold 16-bit words, so nothing else can be served
    if (DATA_W != 16)
    begin : g_width_check
        $error("imm_jump_decoder: only a 16-bit data word is supported");
    end

    // Reset released through two flops so release is glitch free
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_n_q <= 1'b0;
            rst_n_q      <= 1'b0;
        end
        else
        begin
            rst_meta_n_q <= 1'b1;
            rst_n_q      <= rst_meta_n_q;
        end
    end

    // Field split of the fetched word
    assign opcode      = fetch.word[`OPC_HI:`OPC_LO];
    assign imm         = fetch.word[`IMM_HI:`IMM_LO];
    assign acc_gt_zero = !fetch.acc[`ACC_SIGN_BIT] && (fetch.acc != 16'h0000);

    // Byte-immediate opcode to destination and operation
    always_comb
    begin
        is_imm   = 1'b1;
        to_index = 1'b0;
        alu_op   = ALU_ADD;
        case (opcode)
            `OPC_ADD_IMM_ACC:        alu_op = ALU_ADD;
            `OPC_ADD_IMM_INDEX:      to_index = 1'b1;
            `OPC_SUB_IMM_ACC:        alu_op = ALU_SUB;
            `OPC_SUB_IMM_INDEX:
            begin
                alu_op   = ALU_SUB;
                to_index = 1'b1;
            end
            `OPC_CMP_IMM_ACC_SKIP:   alu_op = ALU_POS;
            `OPC_CMP_IMM_INDEX_SKIP:
            begin
                alu_op   = ALU_POS;
                to_index = 1'b1;
            end
            `OPC_LOAD_POS_IMM_ACC:   alu_op = ALU_POS;
            `OPC_LOAD_POS_IMM_INDEX:
            begin
                alu_op   = ALU_POS;
                to_index = 1'b1;
            end
            `OPC_LOAD_NEG_IMM_ACC:   alu_op = ALU_NEG;
            `OPC_LOAD_NEG_IMM_INDEX:
            begin
                alu_op   = ALU_NEG;
                to_index = 1'b1;
            end
            default:                 is_imm = 1'b0;
        endcase
    end

    // One shared arithmetic unit; the destination picks its operand
    assign alu_operand = to_index ? fetch.index : fetch.acc;

    imm_alu #(
        .DATA_W (DATA_W),
        .IMM_W  (8)
    ) u_alu (
        .operand (alu_operand),
        .imm     (imm),
        .op      (alu_op),
        .result  (alu_result)
    );

    // Next state: one instruction per valid cycle, outcome one cycle later
    always_comb
    begin
        logic        take;
        logic        any_cond;
        logic        is_cmp;
        take     = 1'b0;
        any_cond = 1'b0;
        is_cmp   = (opcode == `OPC_CMP_IMM_ACC_SKIP) || (opcode == `OPC_CMP_IMM_INDEX_SKIP);
        s_d      = s_q;
        // Pulses fall back each cycle
        s_d.res.done       = 1'b0;
        s_d.res.acc_we     = 1'b0;
        s_d.res.index_we   = 1'b0;
        s_d.res.skip       = 1'b0;
        s_d.res.jump_taken = 1'b0;
        s_d.res.unhandled  = 1'b0;
        if (fetch.valid)
        begin
            s_d.res.done    = 1'b1;
            s_d.res.pc_next = fetch.pc + `PC_STEP_NEXT;
            if (is_imm && is_cmp)
            begin
                // Compare never writes; a mismatch jumps one word further
                if (alu_result != alu_operand)
                begin
                    s_d.res.skip    = 1'b1;
                    s_d.res.pc_next = fetch.pc + `PC_STEP_SKIP;
                end
            end
            else if (is_imm)
            begin
                s_d.res.acc_we      = !to_index;
                s_d.res.index_we    = to_index;
                s_d.res.acc_wdata   = alu_result;
                s_d.res.index_wdata = alu_result;
            end
            else
            begin
                // Exact jump skeletons first, general form takes top nibble 2, any other word is unhandled
                if (fetch.word == `WORD_JUMP_ACC_GT_ZERO)
                    take = acc_gt_zero;
                else if (fetch.word == `WORD_JUMP_SENSE_ON)
                    take = fetch.sense;
                else if (fetch.word == `WORD_JUMP_SENSE_OFF)
                    take = !fetch.sense;
                else if (fetch.word[`NIB_HI:`NIB_LO] == `NIB_JUMP_ON_COND)
                begin
                    // OR of selected tests, optionally inverted
                    any_cond = (fetch.word[`COND_BIT_ACC_GT_ZERO] && acc_gt_zero)
                             | (fetch.word[`COND_BIT_ACC_ZERO] && (fetch.acc == 16'h0000))
                             | (fetch.word[`COND_BIT_SENSE_ON] && fetch.sense)
                             | (fetch.word[`COND_BIT_ACC_MINUS] && fetch.acc[`ACC_SIGN_BIT]);
                    take = any_cond ^ fetch.word[`COND_BIT_INVERT];
                end
                else
                    s_d.res.unhandled = 1'b1;
                if (take)
                begin
                    s_d.res.jump_taken = 1'b1;
                    s_d.res.pc_next    = fetch.target;
                end
            end
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign result_q = s_q.res;

    // Checks on the registered outcome
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!rst_n_q);

    add_acc_a: assert property (
        fetch.valid && fetch.word[15:8] == `OPC_ADD_IMM_ACC |=>
        result_q.acc_we && !result_q.index_we &&
        result_q.acc_wdata == 16'($past(fetch.acc) + {8'h00, $past(fetch.word[7:0])}))
        else $error("add to accumulator wrong");

    sub_index_a: assert property (
        fetch.valid && fetch.word[15:8] == `OPC_SUB_IMM_INDEX |=>
        result_q.index_we && !result_q.acc_we &&
        result_q.index_wdata == 16'($past(fetch.index) - {8'h00, $past(fetch.word[7:0])}))
        else $error("subtract from index wrong");

    cmp_acc_a: assert property (
        fetch.valid && fetch.word[15:8] == `OPC_CMP_IMM_ACC_SKIP |=>
        !result_q.acc_we && !result_q.index_we &&
        result_q.skip == ($past(fetch.acc) != {8'h00, $past(fetch.word[7:0])}))
        else $error("accumulator compare skip wrong");

    cmp_index_a: assert property (
        fetch.valid && fetch.word[15:8] == `OPC_CMP_IMM_INDEX_SKIP |=>
        result_q.skip == ($past(fetch.index) != {8'h00, $past(fetch.word[7:0])}))
        else $error("index compare skip wrong");

    load_neg_a: assert property (
        fetch.valid && fetch.word[15:8] == `OPC_LOAD_NEG_IMM_ACC |=>
        result_q.acc_we && (16'(result_q.acc_wdata + {8'h00, $past(fetch.word[7:0])}) == 16'h0000))
        else $error("load negative to accumulator wrong");

    load_pos_index_a: assert property (
        fetch.valid && fetch.word[15:8] == `OPC_LOAD_POS_IMM_INDEX |=>
        result_q.index_we && result_q.index_wdata == {8'h00, $past(fetch.word[7:0])})
        else $error("load positive to index wrong");

    add_index_a: assert property (
        fetch.valid && fetch.word[15:8] == `OPC_ADD_IMM_INDEX |=>
        result_q.index_we && !result_q.acc_we &&
        result_q.index_wdata == 16'($past(fetch.index) + {8'h00, $past(fetch.word[7:0])}))
        else $error("add to index wrong");

    sub_acc_a: assert property (
        fetch.valid && fetch.word[15:8] == `OPC_SUB_IMM_ACC |=>
        result_q.acc_we && !result_q.index_we &&
        result_q.acc_wdata == 16'($past(fetch.acc) - {8'h00, $past(fetch.word[7:0])}))
        else $error("subtract from accumulator wrong");

    load_pos_acc_a: assert property (
        fetch.valid && fetch.word[15:8] == `OPC_LOAD_POS_IMM_ACC |=>
        result_q.acc_we && !result_q.index_we &&
        result_q.acc_wdata == {8'h00, $past(fetch.word[7:0])})
        else $error("load positive to accumulator wrong");

    load_neg_index_a: assert property (
        fetch.valid && fetch.word[15:8] == `OPC_LOAD_NEG_IMM_INDEX |=>
        result_q.index_we && !result_q.acc_we &&
        (16'(result_q.index_wdata + {8'h00, $past(fetch.word[7:0])}) == 16'h0000))
        else $error("load negative to index wrong");

    acc_gt_jump_a: assert property (
        fetch.valid && fetch.word == `WORD_JUMP_ACC_GT_ZERO |=>
        result_q.jump_taken == ($past(fetch.acc) != 16'h0000 && !$past(fetch.acc[15])))
        else $error("accumulator greater than zero jump wrong");

    sense_jump_a: assert property (
        fetch.valid && fetch.word == `WORD_JUMP_SENSE_ON |=>
        result_q.jump_taken == $past(fetch.sense))
        else $error("sense on jump wrong");

    sense_off_a: assert property (
        fetch.valid && fetch.word == `WORD_JUMP_SENSE_OFF |=>
        result_q.done && result_q.jump_taken == !$past(fetch.sense))
        else $error("sense off jump wrong");

    pc_step_a: assert property (
        fetch.valid |=>
        result_q.done &&
        (result_q.jump_taken ? result_q.pc_next == $past(fetch.target)
         : result_q.pc_next == 16'($past(fetch.pc)
                                   + (result_q.skip ? `PC_STEP_SKIP : `PC_STEP_NEXT))))
        else $error("program counter step wrong");

endmodule

// [design/imm_jump_pkg.sv]
// Types shared by the immediate/jump decoder and its arithmetic unit
package imm_jump_pkg;

    // Operation of the immediate arithmetic unit
    typedef enum logic [1:0] {
        ALU_ADD,
        ALU_SUB,
        ALU_POS,
        ALU_NEG
    } alu_op_t;

    // Fetched instruction together with the datapath view it needs
    typedef struct packed {
        logic        valid;
        logic [15:0] word;
        logic [15:0] acc;
        logic [15:0] index;
        logic [15:0] pc;
        logic [15:0] target;
        logic        sense;
    } fetch_t;

    // Registered outcome of one executed instruction
    typedef struct packed {
        logic        done;
        logic        acc_we;
        logic [15:0] acc_wdata;
        logic        index_we;
        logic [15:0] index_wdata;
        logic [15:0] pc_next;
        logic        skip;
        logic        jump_taken;
        logic        unhandled;
    } exec_result_t;

    // Whole state of the decoder
    typedef struct packed {
        exec_result_t res;
    } dec_state_t;

endpackage

// [testbench/byte_immediate_and_cond_jump_decode_tb.sv]
// Self-checking bench for the immediate and conditional jump decoder
module byte_immediate_and_cond_jump_decode_tb;
    import imm_jump_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // One word and the state it should leave
    typedef struct packed {
        logic [15:0] word;
        logic        sense;
        logic [5:0]  flags; // done, acc_we, index_we, skip, jump_taken, unhandled
        logic [15:0] acc;
        logic [15:0] index;
        logic [15:0] pc;
    } row_t;

    logic         core_clk    = 1'b0;     // 25 MHz clock
    logic         arst_n      = 1'b0;     // Reset, held at start
    logic         valid       = 1'b0;     // Word present
    logic [15:0]  word        = 16'h0000; // Instruction word
    logic         sense       = 1'b0;     // Sense indicator
    logic [15:0]  target      = 16'h0040; // Fixed jump destination
    fetch_t       fetch;                  // View into the decoder
    exec_result_t result_q;               // Decoder outcome
    int           miscompares = 0;
    int           check_count = 0;
    int           cycles      = 0;

    // Program run in order; each row depends on the rows above it
    row_t rows [25] = '{
        '{16'hc605, 1'b0, 6'h30, 16'h0005, 16'h0000, 16'h0001},
        '{16'h0b0a, 1'b0, 6'h30, 16'h000f, 16'h0000, 16'h0002},
        '{16'h0d10, 1'b0, 6'h30, 16'hffff, 16'h0000, 16'h0003},
        '{16'hc7ff, 1'b0, 6'h30, 16'hff01, 16'h0000, 16'h0004},
        '{16'hc480, 1'b0, 6'h28, 16'hff01, 16'h0080, 16'h0005},
        '{16'hc2f0, 1'b0, 6'h28, 16'hff01, 16'h0170, 16'h0006},
        '{16'hc301, 1'b0, 6'h28, 16'hff01, 16'h016f, 16'h0007},
        '{16'hc502, 1'b0, 6'h28, 16'hff01, 16'hfffe, 16'h0008},
        '{16'hc001, 1'b0, 6'h24, 16'hff01, 16'hfffe, 16'h000a},
        '{16'hc1fe, 1'b0, 6'h24, 16'hff01, 16'hfffe, 16'h000c},
        '{16'h3180, 1'b0, 6'h20, 16'hff01, 16'hfffe, 16'h000d},
        '{16'hc601, 1'b0, 6'h30, 16'h0001, 16'hfffe, 16'h000e},
        '{16'hc001, 1'b0, 6'h20, 16'h0001, 16'hfffe, 16'h000f},
        '{16'h3180, 1'b0, 6'h22, 16'h0001, 16'hfffe, 16'h0040},
        '{16'hc4fe, 1'b0, 6'h28, 16'h0001, 16'h00fe, 16'h0041},
        '{16'hc1fe, 1'b0, 6'h20, 16'h0001, 16'h00fe, 16'h0042},
        '{16'h3400, 1'b0, 6'h20, 16'h0001, 16'h00fe, 16'h0043},
        '{16'h2400, 1'b0, 6'h22, 16'h0001, 16'h00fe, 16'h0040},
        '{16'h3400, 1'b1, 6'h22, 16'h0001, 16'h00fe, 16'h0040},
        '{16'h2400, 1'b1, 6'h20, 16'h0001, 16'h00fe, 16'h0041},
        '{16'h2200, 1'b1, 6'h22, 16'h0001, 16'h00fe, 16'h0040},
        '{16'h2a00, 1'b1, 6'h20, 16'h0001, 16'h00fe, 16'h0041},
        '{16'h1234, 1'b0, 6'h21, 16'h0001, 16'h00fe, 16'h0042},
        '{16'hc600, 1'b0, 6'h30, 16'h0000, 16'h00fe, 16'h0043},
        '{16'h2100, 1'b0, 6'h22, 16'h0000, 16'h00fe, 16'h0040}
    };

    // Far side of the decoder
    datapath_model partner (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .valid    (valid),
        .word     (word),
        .sense    (sense),
        .target   (target),
        .result   (result_q),
        .fetch    (fetch)
    );

    // Decoder under test
    imm_jump_decoder dut (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .fetch    (fetch),
        .result_q (result_q)
    );

    // 40 ns period
    always #20 core_clk = ~core_clk;

    // Pulse outputs gathered into one value
    function automatic logic [15:0] flags_of();
        return {10'h000, result_q.done, result_q.acc_we, result_q.index_we,
                result_q.skip, result_q.jump_taken, result_q.unhandled};
    endfunction

    // Single comparison point
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    // One word, then its pulses, then the state it left
    task automatic run_row(input row_t r);
        @(negedge core_clk);
        valid = 1'b1;
        word  = r.word;
        sense = r.sense;
        @(negedge core_clk);
        valid = 1'b0;
        check("flags", flags_of(), {10'h000, r.flags});
        @(negedge core_clk);
        check("pulses low", flags_of(), 16'h0000);
        check("acc", fetch.acc, r.acc);
        check("index", fetch.index, r.index);
        check("pc", fetch.pc, r.pc);
    endtask

    // Closing report
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Hang guard, far above the roughly 110 cycles needed
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    // Main sequence
    initial
    begin
        repeat (20) @(negedge core_clk);
        check("in reset", 16'(result_q !== '0), 16'h0000);
        arst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        check("after release", 16'(result_q !== '0), 16'h0000);
        foreach (rows[i])
            run_row(rows[i]);
        // Back to back: acc then index with no gap
        @(negedge core_clk);
        valid = 1'b1;
        word  = 16'hc633;
        @(negedge core_clk);
        word  = 16'hc455;
        check("b2b first", flags_of(), 16'h0030);
        check("b2b acc data", result_q.acc_wdata, 16'h0033);
        @(negedge core_clk);
        valid = 1'b0;
        check("b2b second", flags_of(), 16'h0028);
        check("b2b index data", result_q.index_wdata, 16'h0055);
        check("b2b pc", result_q.pc_next, 16'h0042);
        // Reset in mid-run clears the answer at once
        @(negedge core_clk);
        valid = 1'b1;
        word  = 16'hc6aa;
        @(negedge core_clk);
        valid  = 1'b0;
        arst_n = 1'b0;
        #1;
        check("mid reset", 16'(result_q !== '0), 16'h0000);
        repeat (3) @(negedge core_clk);
        arst_n = 1'b1;
        @(negedge core_clk);
        check("first edge after release", 16'(result_q !== '0), 16'h0000);
        @(negedge core_clk);
        check("second edge after release", 16'(result_q !== '0), 16'h0000);
        run_row(rows[0]);
        print_verdict();
    end
endmodule

// [testbench/datapath_model.sv]
// Fetch and register datapath model that faces the decoder
module datapath_model
    import imm_jump_pkg::*;
(
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         arst_n,
    // Instruction stream from the bench
    input  wire logic         valid,
    input  wire logic [15:0]  word,
    input  wire logic         sense,
    input  wire logic [15:0]  target,
    // Decoder outcome, and the view handed back to it
    input  wire exec_result_t result,
    output fetch_t            fetch
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] acc_q;   // Accumulator
    logic [15:0] index_q; // Index register
    logic [15:0] pc_q;    // Program counter
    logic [15:0] acc_view;   // Accumulator as the offered word sees it
    logic [15:0] index_view; // Index as the offered word sees it
    logic [15:0] pc_view;    // Address of the offered word

    // Registers take the answer one edge after it appears
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            acc_q   <= 16'h0000;
            index_q <= 16'h0000;
            pc_q    <= 16'h0000;
        end
        else if (result.done)
        begin
            if (result.acc_we)
                acc_q <= result.acc_wdata;
            if (result.index_we)
                index_q <= result.index_wdata;
            pc_q <= result.pc_next;
        end
    end

    // A word right behind its predecessor sees that answer forwarded
    assign acc_view   = (result.done && result.acc_we) ? result.acc_wdata : acc_q;
    assign index_view = (result.done && result.index_we) ? result.index_wdata : index_q;
    assign pc_view    = result.done ? result.pc_next : pc_q;

    // Register view travels with every word
    assign fetch = {valid, word, acc_view, index_view, pc_view, target, sense};
endmodule
